// ---- core/cc_bit_timer.sv ----
// Purpose: caption bit clock with 16 phase steps per bit period
// Assumes: run is high only while a caption waveform is being sent
// Notes: phase restarts at zero whenever run falls
`timescale 1ns/1ps
`include "cc_map.svh"
module cc_bit_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  // Timing outputs
  output logic [3:0] phase,
  output logic bitTick
);
  localparam logic [3:0] SUB_LAST = 4'(`CC_SUB_CYC - 1);

  logic [3:0] sub_ff;
  logic [3:0] nxt_sub;
  logic [3:0] phase_ff;
  logic [3:0] nxt_phase;
  logic subEnd;

  // Sub-step divider and phase count
  always_comb begin
    subEnd = run && (sub_ff == SUB_LAST);
    nxt_sub = sub_ff;
    nxt_phase = phase_ff;
    if (!run) begin
      nxt_sub = 4'h0;
      nxt_phase = 4'h0;
    end else if (subEnd) begin
      nxt_sub = 4'h0;
      nxt_phase = phase_ff + 4'h1;
    end else begin
      nxt_sub = sub_ff + 4'h1;
    end
  end

  // Register the divider
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sub_ff <= 4'h0;
      phase_ff <= 4'h0;
    end else begin
      sub_ff <= nxt_sub;
      phase_ff <= nxt_phase;
    end
  end

  assign phase = phase_ff;
  // One pulse at the end of each bit period
  assign bitTick = subEnd && (phase_ff == 4'hf);
endmodule

// ---- core/cc_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz ref_clk, APB with 32-bit data, byte addresses
// Notes: definitions only
`ifndef CC_MAP_SVH
`define CC_MAP_SVH

// Register byte offsets
`define CC_OFF_TIMING0 12'h000
`define CC_OFF_DATA0 12'h004
`define CC_OFF_DATA1 12'h008
`define CC_OFF_EXT0 12'h00c
`define CC_OFF_EXT1 12'h010
`define CC_OFF_CTRL 12'h014
`define CC_OFF_STATUS 12'h018

// Timing register 0 fields
`define CC_MODE_LSB 0
`define CC_MODE_MSB 2
`define CC_TRESET_BIT 7
// Control register fields
`define CC_CTRL_PRI_BIT 0
`define CC_CTRL_EXT_BIT 1

// Reset values
`define CC_TIMING0_RST 8'h00
`define CC_DATA_RST 8'h00
`define CC_CTRL_RST 2'h3

// Caption line numbers
`define CC_LINE_ODD 10'h015
`define CC_LINE_EVEN_IGN 10'h11a
`define CC_LINE_EVEN_EXT 10'h11c

// Waveform sample levels
`define CC_LVL_BLANK 8'h10
`define CC_LVL_HIGH 8'h50

// Frame of a caption line, in bit periods
`define CC_RUNIN_BITS 5'h07
`define CC_GAP_BITS 5'h02
`define CC_DATA_BITS 5'h10

// Timing: clock period, bit period, start delay after line start
`define CC_CLK_PS 10000
`define CC_BIT_PS 1986000
`define CC_PHASES 16
`define CC_SUB_CYC (`CC_BIT_PS / (`CC_CLK_PS * `CC_PHASES))
`define CC_START_NS 10500
`define CC_START_CYC ((`CC_START_NS * 1000) / `CC_CLK_PS)

`endif

// ---- core/cc_pkg.sv ----
// Purpose: types shared by the caption inserter files
// Assumes: nothing
// Notes: constants live in cc_map.svh
package cc_pkg;
  typedef enum logic [2:0] {
    IDLE, WAIT, RUNIN, GAP, START, DATA
  } ccState_e;
  typedef logic [2:0] timingMode_t;
  typedef logic [7:0] sample_t;
endpackage

// ---- core/closed_caption_line_inserter.sv ----
// Purpose: insert caption waveforms into the encoder's video line
// Assumes: line timing inputs come from logic on ref_clk
// Notes: APB slave, zero wait states
`timescale 1ns/1ps
`include "cc_map.svh"
module closed_caption_line_inserter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line timing from the encoder
  input wire logic lineStart,
  input wire logic [9:0] lineNumber,
  input wire logic oddField,
  // Video samples
  input wire cc_pkg::sample_t pixelIn,
  output cc_pkg::sample_t videoOut,
  output logic captionActive,
  // Timing mode to the encoder
  output cc_pkg::timingMode_t timingMode
);
  import cc_pkg::*;

  localparam logic [10:0] START_LAST = 11'(`CC_START_CYC - 1);

  // Registers
  logic [7:0] timing0_ff, nxt_timing0;
  logic [7:0] data0_ff, nxt_data0;
  logic [7:0] data1_ff, nxt_data1;
  logic [7:0] ext0_ff, nxt_ext0;
  logic [7:0] ext1_ff, nxt_ext1;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;
  timingMode_t mode_ff, nxt_mode;
  logic treset_ff, nxt_treset;
  // Caption engine
  ccState_e state_ff, nxt_state;
  logic [10:0] wait_ff, nxt_wait;
  logic [4:0] bits_ff, nxt_bits;
  logic [15:0] shift_ff, nxt_shift;
  logic ext_ff, nxt_ext;
  sample_t video_ff, nxt_video;
  logic active_ff, nxt_active;

  logic wrEn;
  logic setup;
  logic mapped;
  logic [31:0] rdMux;
  logic [3:0] phase;
  logic bitTick;
  logic timerRun;
  logic onPriLine;
  logic onExtLine;
  logic onIgnLine;
  sample_t capLevel;

  // Run-in sine, one full cycle per bit period around mid level
  function automatic sample_t sine_lvl(input logic [3:0] ph);
    case (ph)
      4'h0: sine_lvl = 8'h30;
      4'h1: sine_lvl = 8'h3c;
      4'h2: sine_lvl = 8'h47;
      4'h3: sine_lvl = 8'h4e;
      4'h4: sine_lvl = 8'h50;
      4'h5: sine_lvl = 8'h4e;
      4'h6: sine_lvl = 8'h47;
      4'h7: sine_lvl = 8'h3c;
      4'h8: sine_lvl = 8'h30;
      4'h9: sine_lvl = 8'h24;
      4'ha: sine_lvl = 8'h19;
      4'hb: sine_lvl = 8'h12;
      4'hc: sine_lvl = 8'h10;
      4'hd: sine_lvl = 8'h12;
      4'he: sine_lvl = 8'h19;
      default: sine_lvl = 8'h24;
    endcase
  endfunction

  // APB decode
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      `CC_OFF_TIMING0: rdMux = {24'h00_0000, timing0_ff};
      `CC_OFF_DATA0: rdMux = {24'h00_0000, data0_ff};
      `CC_OFF_DATA1: rdMux = {24'h00_0000, data1_ff};
      `CC_OFF_EXT0: rdMux = {24'h00_0000, ext0_ff};
      `CC_OFF_EXT1: rdMux = {24'h00_0000, ext1_ff};
      `CC_OFF_CTRL: rdMux = {30'h0000_0000, ctrl_ff};
      `CC_OFF_STATUS: rdMux = {24'h00_0000, ext_ff, mode_ff, active_ff,
                               state_ff};
      default: mapped = 1'b0;
    endcase
  end

  // Register writes, read data capture and timing mode apply
  always_comb begin
    nxt_timing0 = timing0_ff;
    nxt_data0 = data0_ff;
    nxt_data1 = data1_ff;
    nxt_ext0 = ext0_ff;
    nxt_ext1 = ext1_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rdata = rdata_ff;
    nxt_mode = mode_ff;
    nxt_treset = timing0_ff[`CC_TRESET_BIT];
    if (setup) begin
      nxt_rdata = mapped ? rdMux : 32'h0000_0000;
    end
    if (wrEn) begin
      case (paddr)
        `CC_OFF_TIMING0: nxt_timing0 = pwdata[7:0];
        `CC_OFF_DATA0: nxt_data0 = pwdata[7:0];
        `CC_OFF_DATA1: nxt_data1 = pwdata[7:0];
        `CC_OFF_EXT0: nxt_ext0 = pwdata[7:0];
        `CC_OFF_EXT1: nxt_ext1 = pwdata[7:0];
        `CC_OFF_CTRL: nxt_ctrl = pwdata[1:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (timing0_ff[`CC_TRESET_BIT] != treset_ff) begin
      nxt_mode = timing0_ff[`CC_MODE_MSB:`CC_MODE_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timing0_ff <= `CC_TIMING0_RST;
      data0_ff <= `CC_DATA_RST;
      data1_ff <= `CC_DATA_RST;
      ext0_ff <= `CC_DATA_RST;
      ext1_ff <= `CC_DATA_RST;
      ctrl_ff <= `CC_CTRL_RST;
      rdata_ff <= 32'h0000_0000;
      mode_ff <= 3'h0;
      treset_ff <= 1'b0;
    end else begin
      timing0_ff <= nxt_timing0;
      data0_ff <= nxt_data0;
      data1_ff <= nxt_data1;
      ext0_ff <= nxt_ext0;
      ext1_ff <= nxt_ext1;
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      mode_ff <= nxt_mode;
      treset_ff <= nxt_treset;
    end
  end

  assign prdata = rdata_ff;
  assign timingMode = mode_ff;

  cc_bit_timer bitTimer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(timerRun),
    .phase(phase),
    .bitTick(bitTick)
  );
  assign timerRun = (state_ff != IDLE) && (state_ff != WAIT);

  // Caption line detection
  // Odd field line
  assign onPriLine = oddField && (lineNumber == `CC_LINE_ODD);
  assign onExtLine = !oddField && (lineNumber == `CC_LINE_EVEN_EXT);
  assign onIgnLine = onPriLine || onExtLine ||
                     (!oddField && (lineNumber == `CC_LINE_EVEN_IGN));

  // Caption line sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    nxt_bits = bits_ff;
    nxt_shift = shift_ff;
    nxt_ext = ext_ff;
    case (state_ff)
      IDLE: begin
        nxt_wait = 11'h000;
        nxt_bits = 5'h00;
      end
      WAIT: begin
        nxt_wait = wait_ff + 11'h001;
        if (wait_ff == START_LAST) begin
          nxt_state = RUNIN;
          nxt_bits = 5'h00;
        end
      end
      RUNIN: if (bitTick) begin
        nxt_bits = bits_ff + 5'h01;
        if (bits_ff == `CC_RUNIN_BITS - 5'h01) begin
          nxt_state = GAP;
          nxt_bits = 5'h00;
        end
      end
      GAP: if (bitTick) begin
        nxt_bits = bits_ff + 5'h01;
        if (bits_ff == `CC_GAP_BITS - 5'h01) begin
          nxt_state = START;
          nxt_bits = 5'h00;
        end
      end
      START: if (bitTick) begin
        nxt_state = DATA;
      end
      DATA: if (bitTick) begin
        nxt_shift = {1'b0, shift_ff[15:1]};
        nxt_bits = bits_ff + 5'h01;
        if (bits_ff == `CC_DATA_BITS - 5'h01) begin
          nxt_state = IDLE;
        end
      end
      default: nxt_state = IDLE;
    endcase
    // A new line restarts the sequencer
    if (lineStart) begin
      nxt_state = IDLE;
      nxt_wait = 11'h000;
      nxt_bits = 5'h00;
      if (onPriLine && ctrl_ff[`CC_CTRL_PRI_BIT]) begin
        nxt_state = WAIT;
        nxt_shift = {data1_ff, data0_ff};
        nxt_ext = 1'b0;
      end else if (onExtLine && ctrl_ff[`CC_CTRL_EXT_BIT]) begin
        nxt_state = WAIT;
        nxt_shift = {ext1_ff, ext0_ff};
        nxt_ext = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff <= IDLE;
      wait_ff <= 11'h000;
      bits_ff <= 5'h00;
      shift_ff <= 16'h0000;
      ext_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      bits_ff <= nxt_bits;
      shift_ff <= nxt_shift;
      ext_ff <= nxt_ext;
    end
  end

  // Waveform level for the current sequencer state
  always_comb begin
    case (state_ff)
      RUNIN: capLevel = sine_lvl(phase);
      START: capLevel = `CC_LVL_HIGH;
      DATA: capLevel = shift_ff[0] ? `CC_LVL_HIGH : `CC_LVL_BLANK;
      default: capLevel = `CC_LVL_BLANK;
    endcase
  end

  // Output sample select
  always_comb begin
    nxt_active = timerRun;
    nxt_video = onIgnLine ? capLevel : pixelIn;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      video_ff <= `CC_LVL_BLANK;
      active_ff <= 1'b0;
    end else begin
      video_ff <= nxt_video;
      active_ff <= nxt_active;
    end
  end

  assign videoOut = video_ff;
  assign captionActive = active_ff;
endmodule

// ---- tb/cc_assertions.sv ----
// Purpose: port checks of the caption inserter
// Assumes: one clock domain
// Notes: bound to the design top
`timescale 1ns/1ps
module cc_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Video
  input wire logic lineStart,
  input wire logic [9:0] lineNumber,
  input wire logic oddField,
  input wire cc_pkg::sample_t pixelIn,
  input wire cc_pkg::sample_t videoOut,
  input wire logic captionActive,
  input wire cc_pkg::timingMode_t timingMode
);
  import cc_pkg::*;
  logic [12:0] since_ff, nxt_since, act_ff, nxt_act;
  logic [2:0] age_ff, nxt_age;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  function automatic logic capL(input logic [9:0] ln);
    return ln == 10'h015 || ln == 10'h11a || ln == 10'h11c;
  endfunction
  // Ages since line start, caption start and timing write
  always_comb begin
    nxt_since = lineStart ? 13'h0000 : since_ff + {12'h000, ~&since_ff};
    nxt_act = captionActive ? act_ff + 13'h0001 : 13'h0000;
    nxt_age = (psel && penable && pwrite && paddr == 12'h000) ? 3'h0 :
      age_ff + {2'h0, ~&age_ff};
  end
  always_ff @(posedge ref_clk) begin
    since_ff <= rstn ? nxt_since : 13'h1fff;
    act_ff <= rstn ? nxt_act : 13'h0000;
    age_ff <= rstn ? nxt_age : 3'h7;
  end
  sequence sGap;
    captionActive && act_ff == 13'd1400;
  endsequence
  sequence sStart;
    captionActive && act_ff == 13'd1800;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (
    psel && penable && paddr > 12'h018 |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (
    psel && penable && paddr <= 12'h018 |-> !pslverr)
    else $error("error on mapped address");
  a_pixel_pass: assert property (
    $past(rstn) && !capL(lineNumber) && !capL($past(lineNumber))
    |-> videoOut == $past(pixelIn))
    else $error("pixel not passed");
  a_ignore_pixel: assert property (
    $past(rstn) && lineNumber == 10'h11a && $past(lineNumber) == 10'h11a
    |-> videoOut == 8'h10)
    else $error("pixel shown on ignored line");
  a_start_delay: assert property (
    $rose(captionActive) |-> since_ff inside {[1048:1056]})
    else $error("caption start delay wrong");
  a_line_select: assert property (
    $rose(captionActive) |-> (lineNumber == 10'h015 && oddField) ||
    (lineNumber == 10'h11c && !oddField))
    else $error("caption on wrong line");
  a_gap_blank: assert property (sGap |-> (videoOut == 8'h10) [*8])
    else $error("gap not blank");
  a_start_high: assert property (sStart |-> (videoOut == 8'h50) [*8])
    else $error("start bit not high");
  a_frame_len: assert property (
    $fell(captionActive) && since_ff > 13'd6000 |->
    act_ff inside {[4988:4996]})
    else $error("caption frame length wrong");
  a_mode_write: assert property (
    $changed(timingMode) |-> age_ff <= 3'h3)
    else $error("mode changed without write");
endmodule

bind closed_caption_line_inserter cc_assertions cc_assertions_i (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .lineStart(lineStart), .lineNumber(lineNumber), .oddField(oddField),
  .pixelIn(pixelIn), .videoOut(videoOut),
  .captionActive(captionActive), .timingMode(timingMode));

// ---- tb/cc_rx_model.sv ----
// Purpose: receiver that slices the caption line
// Assumes: 192 cycles a bit, framing starts with captionActive
// Notes: samples at bit centres
`timescale 1ns/1ps
module cc_rx_model (
  // Clock
  input wire logic ref_clk,
  // Caption line
  input wire cc_pkg::sample_t videoOut,
  input wire logic captionActive,
  // Decoded result
  output logic [15:0] rxWord,
  output logic rxStart,
  output logic rxDone
);
  import cc_pkg::*;
  int n = 0;
  initial rxDone = 1'b0;
  // Slice each bit at its centre
  always @(posedge ref_clk) begin
    n <= captionActive ? n + 1 : 0;
    if (captionActive && n == 0) begin
      rxDone <= 1'b0;
    end
    if (captionActive && n == 9 * 192 + 96) begin
      rxStart <= videoOut > 8'h30;
    end
    if (captionActive && n % 192 == 96 && n >= 1920) begin
      rxWord[n / 192 - 10] <= videoOut > 8'h30;
      rxDone <= n == 25 * 192 + 96;
    end
  end
endmodule

// ---- tb/closed_caption_line_inserter_tb_top.sv ----
// Purpose: self-checking bench of the caption inserter
// Assumes: zero wait APB, NTSC line numbers
// Notes: register cases in a table
`timescale 1ns/1ps
module closed_caption_line_inserter_tb_top;
  import cc_pkg::*;
  logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e, lineStart = 0, oddField = 0;
  logic captionActive, rxStart, rxDone;
  logic [9:0] lineNumber = 10'h064;
  logic [15:0] rxWord;
  sample_t pixelIn = 8'h7e, videoOut;
  timingMode_t timingMode;
  int nMismatch = 0, nTests = 0;
  logic [11:0] tA [6] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
    12'h020};
  logic [31:0] tW [6] = '{32'h1234563c, 32'hc1, 32'h5a, 32'ha6, 32'h3,
    32'hff};
  logic [31:0] tR [6] = '{32'h3c, 32'hc1, 32'h5a, 32'ha6, 32'h3, 32'h0};
  logic tE [6] = '{0, 0, 0, 0, 0, 1};
  always #5 ref_clk = ~ref_clk;
  closed_caption_line_inserter closed_caption_line_inserter_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .lineStart(lineStart),
    .lineNumber(lineNumber),
    .oddField(oddField),
    .pixelIn(pixelIn),
    .videoOut(videoOut),
    .captionActive(captionActive),
    .timingMode(timingMode)
  );
  cc_rx_model cc_rx_model_i (.ref_clk(ref_clk), .videoOut(videoOut),
    .captionActive(captionActive), .rxWord(rxWord), .rxStart(rxStart),
    .rxDone(rxDone));
  task automatic report_and_stop();
    if (nMismatch == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    nTests++;
    if (g !== x) begin
      nMismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      nMismatch++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic line(input logic [9:0] ln, input logic o);
    lineNumber <= ln;
    oddField <= o;
    // A pixel value from the low eight line-number bits, 7e on the plain test line
    pixelIn <= ln[7:0] ^ 8'h1a;
    cyc(1);
    lineStart <= 1;
    cyc(1);
    lineStart <= 0;
  endtask
  task automatic waitRx(input logic v);
    int k;
    for (k = 0; k < 8000 && rxDone !== v; k++) cyc(1);
    if (k >= 8000) begin
      nMismatch++;
      report_and_stop();
    end
  endtask
  // Reset, table of register cases, then line scenarios
  initial begin
    cyc(20);
    rstn <= 1;
    cyc(1);
    chk(videoOut, 8'h10);
    chk(captionActive, 0);
    chk(timingMode, 0);
    apb(12'h000, 0, 0);
    chk(r, 0);
    apb(12'h014, 0, 0);
    chk(r, 3);
    for (int i = 0; i < 6; i++) begin
      apb(tA[i], 1, tW[i]);
      chk(e, tE[i]);
      apb(tA[i], 0, 0);
      chk(r, tR[i]);
    end
    apb(12'h000, 1, 32'h05);
    cyc(4);
    chk(timingMode, 0);
    apb(12'h000, 1, 32'h85);
    cyc(4);
    chk(timingMode, 5);
    line(10'h064, 1);
    cyc(3);
    chk(videoOut, 8'h7e);
    line(10'h11a, 0);
    cyc(3);
    chk(videoOut, 8'h10);
    // Full frames on lines 21 and 284; even-field line 21 gives none; a new line cuts the last caption short
    line(10'h015, 1);
    waitRx(0);
    waitRx(1);
    chk(rxStart, 1);
    chk(rxWord, 16'hc13c);
    cyc(150);
    chk(captionActive, 0);
    line(10'h11c, 0);
    waitRx(0);
    waitRx(1);
    chk(rxWord, 16'ha65a);
    cyc(150);
    chk(captionActive, 0);
    line(10'h015, 0);
    cyc(1200);
    chk(captionActive, 0);
    line(10'h015, 1);
    cyc(1500);
    chk(captionActive, 1);
    line(10'h064, 1);
    cyc(3);
    chk(captionActive, 0);
    // Extended enable off alone: line 284 stays blank; both off: line 21 stays blank
    apb(12'h014, 1, 1);
    line(10'h11c, 0);
    cyc(1200);
    chk(captionActive, 0);
    chk(videoOut, 8'h10);
    apb(12'h014, 1, 0);
    line(10'h015, 1);
    cyc(1200);
    chk(captionActive, 0);
    chk(videoOut, 8'h10);
    // Status: mode 5 applied, idle, last caption primary
    apb(12'h018, 0, 0);
    chk(r, 32'h50);
    // Reset in mid-run brings back the reset values
    rstn <= 0;
    cyc(2);
    rstn <= 1;
    cyc(1);
    chk(timingMode, 0);
    apb(12'h014, 0, 0);
    chk(r, 3);
    apb(12'h004, 0, 0);
    chk(r, 0);
    report_and_stop();
  end
endmodule
